// *** hdl/ckg_consts.svh ***
`ifndef CKG_CONSTS_SVH
`define CKG_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CKG_OFS_REVV 8'h07
`define CKG_OFS_PID 8'h08
`define CKG_OFS_OCTL 8'h09
`define CKG_OFS_STPX 8'h0A
`define CKG_OFS_STBY 8'h0B
`define CKG_OFS_BCNT 8'h0C
`define CKG_OFS_PLL1 8'h0D

// ****************************************
// Field positions
// ****************************************
`define CKG_B_AUX1 1
`define CKG_B_AUX2 0
`define CKG_B_BUS5 7
`define CKG_B_TRUST 6
`define CKG_B_TSEL 4
`define CKG_B_TENT 3
`define CKG_B_VMSB 2
`define CKG_B_VLSB 1
`define CKG_B_PINF 7
`define CKG_B_HS1 1
`define CKG_B_HS0 0
`define CKG_B_HS2 0
`define CKG_B_GEN2 1
`define CKG_B_SB2 3
`define CKG_B_SB1 2
`define CKG_REF_HI 5
`define CKG_N8 7
`define CKG_N9 6
`define CKG_ID_LO 4

// ****************************************
// Reset values and writable masks
// ****************************************
`define CKG_RST_PID 8'h00
`define CKG_RST_OCTL 8'h24
`define CKG_RST_STPX 8'h03
`define CKG_RST_STBY 8'h05
`define CKG_RST_BCNT 8'h0D
`define CKG_RST_PLL1 8'h00
`define CKG_WM_PID 8'h0F
`define CKG_WM_OCTL 8'hBE
`define CKG_WM_STPX 8'h7F
`define CKG_WM_STBY 8'hFD
`define CKG_WM_BCNT 8'h3F
`define CKG_WM_PLL1 8'hFF
`define CKG_M_TRUST 8'h40
`define CKG_M_PINF 8'h80
`define CKG_M_GEN2 8'h02
`define CKG_ZERO8 8'h00

`endif

// *** hdl/ckg_pkg.sv ***
`default_nettype none
package ckg_pkg;
   // Register port request, one cycle per access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ckg_bus_req_t;

   // Strap pins as seen at the release of reset
   typedef struct packed {
      logic [2:0] freq_sel;
      logic trusted;
      logic pin_func;
      logic test_mode;
      logic test_sel;
      logic div_latch_vld;
      logic [7:0] div_latch;
   } ckg_strap_t;

   // Control bits that steer the output gating
   typedef struct packed {
      logic free_bus_clock_stop_allow;
      logic host_zero_stop_en;
      logic host_one_stop_en;
      logic host_two_stop_en;
      logic host_out_one_standby_enable;
      logic host_out_two_standby_enable;
      logic aux_single_ended_one_enable;
      logic aux_single_ended_two_enable;
   } ckg_gate_ctl_t;

   // Run enables of the gated clock outputs
   typedef struct packed {
      logic free_bus_clock_five;
      logic host_clock_out_zero;
      logic host_clock_out_one;
      logic host_clock_out_two;
      logic single_ended_aux_one;
      logic single_ended_aux_two;
      logic serial_ref_clock_five;
   } ckg_run_t;

   typedef enum logic [2:0] {
      CKG_ST_NORM = 3'b001,
      CKG_ST_HIZ = 3'b010,
      CKG_ST_REFN = 3'b100
   } ckg_tm_state_t;
endpackage
`default_nettype wire

// *** hdl/ckg_strap_latch.sv ***
`default_nettype none
module ckg_strap_latch #(
   parameter logic [63:0] DIV_ROM = 64'h1F1E1D1C1B1A1918
) (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Synchronised reset, low active
   input wire logic ce, // Clock enable
   input wire ckg_pkg::ckg_strap_t straps, // Live strap pins
   output ckg_pkg::ckg_strap_t latched, // Straps held since reset
   output logic load, // One-cycle divider preload strobe
   output logic [7:0] preload // Divider byte to preload
);
   // ****************************************
   // Capture once after reset release
   // ****************************************
   logic done_q;
   logic load_q;
   ckg_pkg::ckg_strap_t latch_q;

   function automatic logic [7:0] rom_pick(input logic [63:0] rom,
                                           input logic [2:0] fs);
      rom_pick = rom[{fs, 3'b000} +: 8];
   endfunction

   // Straps are caught by a clocked process, never by the reset itself
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         load_q <= 1'b0;
         latch_q <= '0;
      end else if (ce) begin
         done_q <= 1'b1;
         load_q <= !done_q;
         if (!done_q) begin
            latch_q <= straps;
         end
      end
   end

   // Latched divider wins over the table when the strap supplies one
   assign preload = latch_q.div_latch_vld ? latch_q.div_latch :
                    rom_pick(DIV_ROM, latch_q.freq_sel);
   assign latched = latch_q;
   assign load = load_q;
endmodule
`default_nettype wire

// *** hdl/ckg_out_gate.sv ***
`default_nettype none
module ckg_out_gate (
   input wire logic clk, // Core clock
   input wire logic rst_n, // Synchronised reset, low active
   input wire logic ce, // Clock enable
   input wire ckg_pkg::ckg_gate_ctl_t ctl, // Gating controls
   input wire logic bus_stop_n, // Bus clock stop, low active
   input wire logic host_stop_n, // Host clock stop, low active
   input wire logic standby, // Management standby state
   input wire logic pin_func, // Shared pins select fifth ref clock
   input wire logic force_off, // Test mode high impedance
   output ckg_pkg::ckg_run_t run // Registered run enables
);
   // ****************************************
   // Stop and standby gating
   // ****************************************
   ckg_pkg::ckg_run_t run_q;
   ckg_pkg::ckg_run_t run_d;
   wire stops_live = !pin_func;
   wire bus_stop = stops_live && !bus_stop_n;
   wire host_stop = stops_live && !host_stop_n;
   wire sb_one = !standby || ctl.host_out_one_standby_enable;
   wire sb_two = !standby || ctl.host_out_two_standby_enable;

   // Stop pins are shared, so they act only when not used for the ref
   always_comb begin
      run_d.free_bus_clock_five = !force_off &&
         !(ctl.free_bus_clock_stop_allow && bus_stop);
      run_d.host_clock_out_zero = !force_off &&
         !(ctl.host_zero_stop_en && host_stop);
      run_d.host_clock_out_one = !force_off && sb_one &&
         !(ctl.host_one_stop_en && host_stop);
      run_d.host_clock_out_two = !force_off && sb_two &&
         !(ctl.host_two_stop_en && host_stop);
      run_d.single_ended_aux_one = !force_off &&
         ctl.aux_single_ended_one_enable;
      run_d.single_ended_aux_two = !force_off &&
         ctl.aux_single_ended_two_enable;
      run_d.serial_ref_clock_five = !force_off && pin_func;
   end

   // Registered so the enables switch cleanly on a clock edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= '0;
      end else if (ce) begin
         run_q <= run_d;
      end
   end

   assign run = run_q;
endmodule
`default_nettype wire

// *** hdl/ckg_regs.sv ***
// Decided for this implementation: strobed register access.
`include "ckg_consts.svh"
`default_nettype none
module ckg_regs #(
   parameter logic [3:0] PART_ID = 4'h6, // Arbitrary value
   parameter logic [3:0] MAKER_CODE = 4'hA, // Arbitrary value
   parameter logic [3:0] REV_CODE = 4'h3, // Arbitrary value
   parameter logic GEN2_STATUS = 1'b0, // Compliance status bit
   parameter logic [63:0] DIV_ROM = 64'h1F1E1D1C1B1A1918 // Div table
) (
   input wire logic clk, // Core clock, 125 MHz
   input wire logic rst_n, // Asynchronous reset, low active
   input wire logic ce, // Clock enable, freezes state when low
   input wire ckg_pkg::ckg_bus_req_t bus_req, // Register request
   output logic [7:0] rdata, // Read data, cycle after the strobe
   input wire ckg_pkg::ckg_strap_t straps, // Strap pins
   input wire logic bus_stop_n, // Bus clock stop, low active
   input wire logic host_stop_n, // Host clock stop, low active
   input wire logic standby, // Management standby state
   output ckg_pkg::ckg_run_t run, // Output run enables
   output logic test_hiz, // Test mode, outputs high impedance
   output logic test_refn, // Test mode, outputs ref over N
   output logic no_overclock, // Trusted strap forbids overclock
   output logic [1:0] io_voltage_select, // I/O voltage code
   output logic [5:0] readback_count, // Block read byte count
   output logic [5:0] pll1_ref_div, // PLL one ref divider
   output logic [1:0] pll1_fb_div_hi // PLL one feedback bits 9:8
);
   // ****************************************
   // Reset synchroniser
   // ****************************************
   logic rst_meta_q;
   logic rst_sync_n;

   // Release is delayed two edges so no flop leaves reset on a glitch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Only bits in the mask take the new value
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] wd,
                                        input logic [7:0] msk);
      merge = (old & ~msk) | (wd & msk);
   endfunction

   // ****************************************
   // Strap capture and output gating
   // ****************************************
   ckg_pkg::ckg_strap_t latched;
   logic div_load;
   logic [7:0] div_preload;
   ckg_pkg::ckg_gate_ctl_t gate_ctl;

   ckg_strap_latch #(
      .DIV_ROM(DIV_ROM)
   ) u_strap (
      .clk(clk),
      .rst_n(rst_sync_n),
      .ce(ce),
      .straps(straps),
      .latched(latched),
      .load(div_load),
      .preload(div_preload)
   );

   // ****************************************
   // Address decode
   // ****************************************
   wire wr_pid = bus_req.wr && hit(bus_req.addr, `CKG_OFS_PID);
   wire wr_octl = bus_req.wr && hit(bus_req.addr, `CKG_OFS_OCTL);
   wire wr_stpx = bus_req.wr && hit(bus_req.addr, `CKG_OFS_STPX);
   wire wr_stby = bus_req.wr && hit(bus_req.addr, `CKG_OFS_STBY);
   wire wr_bcnt = bus_req.wr && hit(bus_req.addr, `CKG_OFS_BCNT);
   wire wr_pll1 = bus_req.wr && hit(bus_req.addr, `CKG_OFS_PLL1);

   // ****************************************
   // Register storage
   // ****************************************
   logic [7:0] pid_q;
   logic [7:0] octl_q;
   logic [7:0] stpx_q;
   logic [7:0] stby_q;
   logic [7:0] bcnt_q;
   logic [7:0] pll1_q;
   logic [7:0] rdata_q;

   // Masks keep read-only positions at zero in storage
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pid_q <= `CKG_RST_PID;
         octl_q <= `CKG_RST_OCTL;
         stpx_q <= `CKG_RST_STPX;
         stby_q <= `CKG_RST_STBY;
         bcnt_q <= `CKG_RST_BCNT;
      end else if (ce) begin
         if (wr_pid) begin
            pid_q <= merge(pid_q, bus_req.wdata, `CKG_WM_PID);
         end
         if (wr_octl) begin
            octl_q <= merge(octl_q, bus_req.wdata, `CKG_WM_OCTL);
         end
         if (wr_stpx) begin
            stpx_q <= merge(stpx_q, bus_req.wdata, `CKG_WM_STPX);
         end
         if (wr_stby) begin
            stby_q <= merge(stby_q, bus_req.wdata, `CKG_WM_STBY);
         end
         if (wr_bcnt) begin
            bcnt_q <= merge(bcnt_q, bus_req.wdata, `CKG_WM_BCNT);
         end
      end
   end

   // Preload strobe fires once after reset and wins over a write
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pll1_q <= `CKG_RST_PLL1;
      end else if (ce) begin
         if (div_load) begin
            pll1_q <= div_preload;
         end else if (wr_pll1) begin
            pll1_q <= merge(pll1_q, bus_req.wdata, `CKG_WM_PLL1);
         end
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   wire [7:0] rd_revv = {REV_CODE, MAKER_CODE};
   wire [7:0] rd_pid = {PART_ID, pid_q[`CKG_ID_LO-1:0]};
   wire [7:0] rd_octl = octl_q |
      (latched.trusted ? `CKG_M_TRUST : `CKG_ZERO8);
   wire [7:0] rd_stpx = stpx_q |
      (latched.pin_func ? `CKG_M_PINF : `CKG_ZERO8);
   wire [7:0] rd_stby = stby_q |
      (GEN2_STATUS ? `CKG_M_GEN2 : `CKG_ZERO8);
   logic [7:0] rd_mux;

   // Unmapped offsets read as zero
   always_comb begin
      case (bus_req.addr)
         `CKG_OFS_REVV: rd_mux = rd_revv;
         `CKG_OFS_PID: rd_mux = rd_pid;
         `CKG_OFS_OCTL: rd_mux = rd_octl;
         `CKG_OFS_STPX: rd_mux = rd_stpx;
         `CKG_OFS_STBY: rd_mux = rd_stby;
         `CKG_OFS_BCNT: rd_mux = bcnt_q;
         `CKG_OFS_PLL1: rd_mux = pll1_q;
         default: rd_mux = `CKG_ZERO8;
      endcase
   end

   // Data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_q <= `CKG_ZERO8;
      end else if (ce) begin
         rdata_q <= bus_req.rd ? rd_mux : `CKG_ZERO8;
      end
   end

   // ****************************************
   // Test mode state machine
   // ****************************************
   ckg_pkg::ckg_tm_state_t tm_q;
   ckg_pkg::ckg_tm_state_t tm_d;
   wire tm_on = octl_q[`CKG_B_TENT] || latched.test_mode;
   // Register select applies when the register made the entry
   wire tm_sel = octl_q[`CKG_B_TENT] ? octl_q[`CKG_B_TSEL] :
                 latched.test_sel;

   // Every state may move anywhere; the decision is fully decoded
   always_comb begin
      case (tm_q)
         ckg_pkg::CKG_ST_NORM,
         ckg_pkg::CKG_ST_HIZ,
         ckg_pkg::CKG_ST_REFN: begin
            if (!tm_on) begin
               tm_d = ckg_pkg::CKG_ST_NORM;
            end else if (tm_sel) begin
               tm_d = ckg_pkg::CKG_ST_REFN;
            end else begin
               tm_d = ckg_pkg::CKG_ST_HIZ;
            end
         end
         default: tm_d = ckg_pkg::CKG_ST_NORM;
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tm_q <= ckg_pkg::CKG_ST_NORM;
      end else if (ce) begin
         tm_q <= tm_d;
      end
   end

   // ****************************************
   // Output gating
   // ****************************************
   assign gate_ctl.free_bus_clock_stop_allow = octl_q[`CKG_B_BUS5];
   assign gate_ctl.host_zero_stop_en = stpx_q[`CKG_B_HS0];
   assign gate_ctl.host_one_stop_en = stpx_q[`CKG_B_HS1];
   assign gate_ctl.host_two_stop_en = stby_q[`CKG_B_HS2];
   assign gate_ctl.host_out_one_standby_enable = stby_q[`CKG_B_SB1];
   assign gate_ctl.host_out_two_standby_enable = stby_q[`CKG_B_SB2];
   assign gate_ctl.aux_single_ended_one_enable = pid_q[`CKG_B_AUX1];
   assign gate_ctl.aux_single_ended_two_enable = pid_q[`CKG_B_AUX2];

   ckg_out_gate u_gate (
      .clk(clk),
      .rst_n(rst_sync_n),
      .ce(ce),
      .ctl(gate_ctl),
      .bus_stop_n(bus_stop_n),
      .host_stop_n(host_stop_n),
      .standby(standby),
      .pin_func(latched.pin_func),
      .force_off(test_hiz),
      .run(run)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata = rdata_q;
   assign test_hiz = (tm_q == ckg_pkg::CKG_ST_HIZ);
   assign test_refn = (tm_q == ckg_pkg::CKG_ST_REFN);
   assign no_overclock = latched.trusted;
   assign io_voltage_select = {octl_q[`CKG_B_VMSB],
                               octl_q[`CKG_B_VLSB]};
   assign readback_count = bcnt_q[`CKG_REF_HI:0];
   assign pll1_ref_div = pll1_q[`CKG_REF_HI:0];
   assign pll1_fb_div_hi = {pll1_q[`CKG_N9], pll1_q[`CKG_N8]};

   // ****************************************
   // Checks
   // ****************************************
   wire host_stop_act = !latched.pin_func && !host_stop_n;
   wire bus_stop_act = !latched.pin_func && !bus_stop_n;
   wire rd_pid_hit = bus_req.rd && hit(bus_req.addr, `CKG_OFS_PID);
   wire rd_octl_hit = bus_req.rd && hit(bus_req.addr, `CKG_OFS_OCTL);
   wire rd_stpx_hit = bus_req.rd && hit(bus_req.addr, `CKG_OFS_STPX);
   wire rd_stby_hit = bus_req.rd && hit(bus_req.addr, `CKG_OFS_STBY);
   wire rd_bcnt_hit = bus_req.rd && hit(bus_req.addr, `CKG_OFS_BCNT);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_n || !ce);

   chk_part_id_read: assert property (
      rd_pid_hit |=> rdata[7:4] == PART_ID)
      else $error("part code read back wrong");
   chk_aux_gate: assert property (
      run.single_ended_aux_one ==
      ($past(pid_q[`CKG_B_AUX1]) && !$past(test_hiz)))
      else $error("aux output does not follow its enable");
   chk_aux_reset: assert property (
      $rose(rst_sync_n) |-> pid_q[`CKG_B_AUX1:`CKG_B_AUX2] == 2'b00)
      else $error("aux enables not off after reset");
   chk_bus5_stop: assert property (
      ($past(rst_sync_n) && $past(ce)) |->
      run.free_bus_clock_five == (!$past(test_hiz) &&
      !($past(octl_q[`CKG_B_BUS5]) && $past(bus_stop_act))))
      else $error("free bus clock five stop wrong");
   chk_trust_read: assert property (
      rd_octl_hit |=> rdata[`CKG_B_TRUST] == $past(latched.trusted))
      else $error("trusted strap readback wrong");
   chk_test_entry: assert property (
      (wr_octl && bus_req.wdata[`CKG_B_TENT]) |=> ##1
      tm_q != ckg_pkg::CKG_ST_NORM)
      else $error("test entry bit did not enter test mode");
   chk_test_exit: assert property (
      (!octl_q[`CKG_B_TENT] && !latched.test_mode) |=>
      tm_q == ckg_pkg::CKG_ST_NORM)
      else $error("test mode held without a cause");
   chk_test_select: assert property (
      octl_q[`CKG_B_TENT] |=>
      test_refn == $past(octl_q[`CKG_B_TSEL]) && !(test_refn && test_hiz))
      else $error("test select not obeyed");
   chk_io_volt: assert property (
      wr_octl |=> io_voltage_select ==
      {$past(bus_req.wdata[`CKG_B_VMSB]), $past(bus_req.wdata[`CKG_B_VLSB])})
      else $error("voltage select did not take the write");
   chk_pin_func_read: assert property (
      rd_stpx_hit |=> rdata[`CKG_B_PINF] == $past(latched.pin_func))
      else $error("pin function readback wrong");
   chk_host_zero_stop: assert property (
      ($past(stpx_q[`CKG_B_HS0]) && $past(host_stop_act))
      |-> !run.host_clock_out_zero)
      else $error("host output zero ran while stopped");
   chk_host_two_stop: assert property (
      (!stby_q[`CKG_B_HS2] && !standby && !test_hiz)
      |=> run.host_clock_out_two)
      else $error("host output two stopped while free running");
   chk_standby_off: assert property (
      (standby && !stby_q[`CKG_B_SB1]) |=> !run.host_clock_out_one)
      else $error("host output one ran in standby");
   chk_count_reserved: assert property (
      rd_bcnt_hit |=> rdata[7:6] == 2'b00)
      else $error("count reserved bits not zero");
   chk_count_reset: assert property (
      $rose(rst_sync_n) |-> bcnt_q == `CKG_RST_BCNT)
      else $error("readback count reset value wrong");
   chk_div_write: assert property (
      (wr_pll1 && !div_load) |=>
      pll1_ref_div == $past(bus_req.wdata[`CKG_REF_HI:0]))
      else $error("ref divider did not take the write");
   chk_div_preload: assert property (
      div_load |=> pll1_q == $past(div_preload))
      else $error("divider preload not applied");
   chk_ro_ignored: assert property (
      rd_stby_hit |=> rdata[`CKG_B_GEN2] == GEN2_STATUS)
      else $error("status bit changed by a write");
endmodule
`default_nettype wire

// *** tb/ckg_host_model.sv ***
`default_nettype none
// ****************************************
// Register port master
// ****************************************
module ckg_host_model (
   input wire logic clk, // Core clock
   input wire logic [7:0] rdata, // Read data
   output ckg_pkg::ckg_bus_req_t req // Register request
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idles until the bench asks
   initial req = '0;
   // Idle address and data flip so no stale value looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, ~a};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, a};
      #1 d = rdata;
   endtask
endmodule
`default_nettype wire

// *** tb/clockgen_ctrl_regs_b7_b13_bench.sv ***
`default_nettype none
// ****************************************
// Register bank bench
// ****************************************
module clockgen_ctrl_regs_b7_b13_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, ce, bus_stop_n, host_stop_n, standby;
   logic test_hiz, test_refn, no_ovc;
   logic [7:0] rdata, v;
   logic [1:0] vsel, fbh;
   logic [5:0] bcnt, mdiv;
   ckg_pkg::ckg_bus_req_t req;
   ckg_pkg::ckg_strap_t straps;
   ckg_pkg::ckg_run_t run;
   int errors = 0;
   int n_tests = 0;
   int cyc = 0;

   ckg_regs uut (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(req),
      .rdata(rdata), .straps(straps), .bus_stop_n(bus_stop_n),
      .host_stop_n(host_stop_n), .standby(standby), .run(run),
      .test_hiz(test_hiz), .test_refn(test_refn), .no_overclock(no_ovc),
      .io_voltage_select(vsel), .readback_count(bcnt),
      .pll1_ref_div(mdiv), .pll1_fb_div_hi(fbh));
   ckg_host_model host (.clk(clk), .rdata(rdata), .req(req));

   // Free running core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Hang guard, far beyond the roughly 126 cycles used
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         errors = errors + 1;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("wrong value at %0t: got %h exp %h", $time, s, e);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, v);
      chk(v, e);
   endtask

   // Gating is registered behind the register, so wait three edges
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Trusted strap set, divider preload from the strap latch
   task automatic t_reset;
      rdchk(8'h07, 8'h3A);
      rdchk(8'h08, 8'h60);
      rdchk(8'h09, 8'h64);
      rdchk(8'h0A, 8'h03);
      rdchk(8'h0B, 8'h05);
      rdchk(8'h0C, 8'h0D);
      rdchk(8'h0D, 8'hA5);
      chk(8'(no_ovc), 8'h01);
      chk(8'(vsel), 8'h02);
      chk(8'(mdiv), 8'h25);
      chk(8'(fbh), 8'h01);
      $display("done reset");
   endtask

   // Read-only bits hold, writable bits land, holes read zero
   task automatic t_access;
      host.wr(8'h08, 8'hFF);
      rdchk(8'h08, 8'h6F);
      host.wr(8'h09, 8'h00);
      rdchk(8'h09, 8'h40);
      chk(8'(vsel), 8'h00);
      host.wr(8'h0A, 8'hFF);
      rdchk(8'h0A, 8'h7F);
      host.wr(8'h0B, 8'hFF);
      rdchk(8'h0B, 8'hFD);
      host.wr(8'h0C, 8'hFF);
      rdchk(8'h0C, 8'h3F);
      chk(8'(bcnt), 8'h3F);
      host.wr(8'h0D, 8'h5A);
      rdchk(8'h0D, 8'h5A);
      host.wr(8'h20, 8'hFF);
      rdchk(8'h20, 8'h00);
      host.wr(8'h08, 8'h02);
      settle();
      chk(8'(run.single_ended_aux_one), 8'h01);
      chk(8'(run.single_ended_aux_two), 8'h00);
      $display("done access");
   endtask

   // Stop participation and standby enables steer the outputs
   task automatic t_gate;
      host.wr(8'h0A, 8'h03);
      host.wr(8'h0B, 8'h05);
      @(posedge clk) host_stop_n <= 1'b0;
      bus_stop_n <= 1'b0;
      settle();
      chk(8'(run.host_clock_out_zero), 8'h00);
      chk(8'(run.host_clock_out_two), 8'h00);
      chk(8'(run.free_bus_clock_five), 8'h01);
      host.wr(8'h0A, 8'h00);
      host.wr(8'h0B, 8'h04);
      host.wr(8'h09, 8'h80);
      settle();
      chk(8'(run.host_clock_out_zero), 8'h01);
      chk(8'(run.host_clock_out_two), 8'h01);
      chk(8'(run.free_bus_clock_five), 8'h00);
      @(posedge clk) host_stop_n <= 1'b1;
      bus_stop_n <= 1'b1;
      standby <= 1'b1;
      settle();
      chk(8'(run.host_clock_out_one), 8'h01);
      chk(8'(run.host_clock_out_two), 8'h00);
      host.wr(8'h0B, 8'h08);
      settle();
      chk(8'(run.host_clock_out_one), 8'h00);
      chk(8'(run.host_clock_out_two), 8'h01);
      @(posedge clk) standby <= 1'b0;
      $display("done gate");
   endtask

   // Clock enable low freezes the bank, so a write made then is lost
   task automatic t_hold;
      @(posedge clk) ce <= 1'b0;
      host.wr(8'h0C, 8'h15);
      @(posedge clk) ce <= 1'b1;
      rdchk(8'h0C, 8'h3F);
      chk(8'(bcnt), 8'h3F);
      $display("done hold");
   endtask

   // Mid-run reset with other straps: table preload, ref pin, strap test
   task automatic t_strap;
      @(posedge clk) rst_n <= 1'b0;
      straps <= '{3'h5, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
      host_stop_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      // Table entry for select 5 is 18h plus 5
      rdchk(8'h0D, 8'h1D);
      rdchk(8'h09, 8'h24);
      rdchk(8'h0A, 8'h83);
      chk(8'(no_ovc), 8'h00);
      chk(8'(mdiv), 8'h1D);
      chk(8'(fbh), 8'h00);
      chk({test_hiz, test_refn, 6'h00}, 8'h40);
      chk(8'(run.serial_ref_clock_five), 8'h01);
      chk(8'(run.host_clock_out_zero), 8'h01);
      host.wr(8'h09, 8'h08);
      settle();
      chk({test_hiz, test_refn, 6'h00}, 8'h80);
      chk(8'(run), 8'h00);
      $display("done strap");
   endtask

   // Register test entry with both strap pins low, select bit picks the state
   task automatic t_test;
      host.wr(8'h09, 8'h08);
      settle();
      chk({test_hiz, test_refn, 6'h00}, 8'h80);
      chk(8'(run), 8'h00);
      host.wr(8'h09, 8'h18);
      settle();
      chk({test_hiz, test_refn, 6'h00}, 8'h40);
      host.wr(8'h09, 8'h00);
      settle();
      chk({test_hiz, test_refn, 6'h00}, 8'h00);
      $display("done test");
   endtask

   // Main sequence
   initial begin
      straps = '{3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'hA5};
      bus_stop_n = 1'b1;
      host_stop_n = 1'b1;
      standby = 1'b0;
      ce = 1'b1;
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_access();
      t_gate();
      t_test();
      t_hold();
      t_strap();
      complete_run();
   end
endmodule
`default_nettype wire
